// ==== vied_defines.svh ====
`ifndef VIED_DEFINES_SVH
`define VIED_DEFINES_SVH
// Contract
// - Evaluate only when delivery control is one
// - Only five named events trigger an evaluation
// - Recognize if no window exit, priority class higher
// - Delivery drops any pending recognition
// - Deliver at boundary with interrupts fully unblocked
// - Same slot as window exits, above external
// - Wake from halt and monitor wait only
// - Set in-service bit, servicing vector, priority class
// - Clear request bit, requesting vector becomes highest
// - Dispatch vector through descriptor table, no exit
// - Shadowed read returns priority nibble zero extended
// - Shadowed write stores nibble, then priority virtualization
// - Unshadowed moves reach the real priority register
// - Access page hits exit unless virtualized
// - Virtualized accesses go to virtual controller page
// - Page hit uses final physical address only
// - Operation is iteration, instruction or event delivery
// - In-service bit x at word 100H plus index
// - Request bit x at word 200H plus index
// - Processor priority lives at offset 0A0H

// Register byte offsets within the page
`define VIED_OFF_TASK_PRIO 12'h080
`define VIED_OFF_PROC_PRIO 12'h0a0
`define VIED_OFF_CTRL 12'h800
`define VIED_OFF_GIS 12'h804
`define VIED_OFF_ACC_FRAME 12'h808
`define VIED_OFF_VPG_FRAME 12'h80c
// Upper address bits selecting the in-service and request word groups
`define VIED_ISR_SEL 5'h02
`define VIED_IRR_SEL 5'h04

// Control register bit positions
`define VIED_CTL_VID 0
`define VIED_CTL_IWE 1
`define VIED_CTL_TPRSH 2
`define VIED_CTL_VACC 3

// Masks and reset values
`define VIED_CLASS_MASK 8'hf0
`define VIED_NO_VECTOR 8'h00
`define VIED_CTRL_RST 4'h0
`define VIED_PAGE_BITS 12
`endif

// ==== vied_pkg.sv ====
package vied_pkg;
  // Activity state of the core as seen by delivery
  typedef enum logic [2:0] {
    VIED_ACT_ACTIVE,
    VIED_ACT_HALT,
    VIED_ACT_MON_WAIT,
    VIED_ACT_SHUTDOWN,
    VIED_ACT_WAIT_STARTUP
  } vied_activity_t;
  typedef logic [7:0] vied_vector_t;
endpackage

// ==== vied_core.sv ====
`timescale 1ns/1ns
`include "vied_defines.svh"
module vied_core import vied_pkg::*; #(
  parameter int PA_W = 44
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic ev_vm_entry_i,
  input wire logic ev_eoi_virt_i,
  input wire logic ev_self_ipi_i,
  input wire vied_vector_t self_ipi_vector_i,
  input wire logic ev_posted_i,
  input wire logic boundary_i,
  input wire logic if_flag_i,
  input wire logic intr_shadow_block_i,
  input wire logic ss_block_i,
  input wire logic higher_event_i,
  input wire vied_activity_t activity_i,
  output logic deliver_o,
  output vied_vector_t deliver_vector_o,
  output logic ext_int_hold_o,
  output logic wake_o,
  output logic recognized_o,
  input wire logic mov_from_tpcr_i,
  input wire logic mov_to_tpcr_i,
  input wire logic [63:0] tpcr_src_i,
  input wire logic [7:0] real_tpr_i,
  output logic [63:0] tpcr_dest_o,
  output logic real_tpr_rd_o,
  output logic real_tpr_wr_o,
  output logic [3:0] real_tpr_wdata_o,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic acc_virt_ok_i,
  input wire logic [PA_W-1:0] acc_phys_addr_i,
  input wire logic op_end_i,
  output logic acc_exit_o,
  output logic acc_redirect_o,
  output logic [PA_W-1:0] acc_redir_addr_o
);

  localparam int FRAME_W = PA_W - `VIED_PAGE_BITS;

  // Page state; the 256-bit vectors are kept as eight words each
  logic [31:0] isr_word [8];
  logic [31:0] irr_word [8];
  logic [31:0] task_prio;
  logic [31:0] proc_prio;
  logic [3:0] ctrl;
  vied_vector_t req_vec;
  vied_vector_t svc_vec;
  logic [FRAME_W-1:0] acc_frame;
  logic [FRAME_W-1:0] vpg_frame;
  logic recognized;
  logic ppr_req;
  logic eval_req;
  logic op_wr_seen;

  logic vid_en;
  logic iwe;
  logic tpr_shadow;
  logic vacc_en;
  assign vid_en = ctrl[`VIED_CTL_VID];
  assign iwe = ctrl[`VIED_CTL_IWE];
  assign tpr_shadow = ctrl[`VIED_CTL_TPRSH];
  assign vacc_en = ctrl[`VIED_CTL_VACC];

  // Flattened views, bit x at word x[7:5], position x[4:0]
  logic [255:0] irr_flat;
  logic [255:0] isr_flat;
  genvar gw;
  generate
    for (gw = 0; gw < 8; gw++) begin : g_flat
      assign irr_flat[gw*32 +: 32] = irr_word[gw];
      assign isr_flat[gw*32 +: 32] = isr_word[gw];
    end
  endgenerate

  // Highest remaining request once the delivered bit is dropped
  logic [255:0] irr_after;
  vied_vector_t next_req_vec;
  logic irr_any;
  always_comb begin
    irr_after = irr_flat;
    irr_after[req_vec] = 1'b0;
    next_req_vec = `VIED_NO_VECTOR;
    irr_any = 1'b0;
    // Single pass, lowest to highest, so the last hit wins
    for (int i = 0; i < 256; i++) begin
      if (irr_after[i]) begin
        next_req_vec = 8'(i);
        irr_any = 1'b1;
      end
    end
    if (!irr_any) begin
      next_req_vec = `VIED_NO_VECTOR;
    end
  end

  // Delivery decision; halted cores are treated as at a boundary
  logic halted;
  logic wakeable;
  logic deliver_now;
  assign halted = (activity_i == VIED_ACT_HALT) || (activity_i == VIED_ACT_MON_WAIT);
  assign wakeable = halted || (activity_i == VIED_ACT_ACTIVE);
  assign deliver_now = vid_en && recognized && wakeable && (boundary_i || halted) &&
                       if_flag_i && !intr_shadow_block_i && !ss_block_i && !iwe &&
                       !higher_event_i;

  // Mov-to with shadow on counts as task-priority virtualization
  logic tpr_virt;
  assign tpr_virt = mov_to_tpcr_i && tpr_shadow;

  // Pipeline of priority update then evaluation, one cycle each
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ppr_req <= 1'b0;
      eval_req <= 1'b0;
    end else if (ce_i) begin
      ppr_req <= vid_en && (ev_vm_entry_i || tpr_virt || ev_eoi_virt_i);
      eval_req <= vid_en && (ppr_req || ev_self_ipi_i || ev_posted_i);
    end
  end

  // Recognition flag; a same-cycle evaluation sees the post-delivery state
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      recognized <= 1'b0;
    end else if (ce_i) begin
      if (eval_req && vid_en) begin
        if (deliver_now) begin
          // Stale state would re-recognize the vector just delivered
          recognized <= !iwe && (next_req_vec[7:4] > req_vec[7:4]);
        end else begin
          recognized <= !iwe && (req_vec[7:4] > proc_prio[7:4]);
        end
      end else if (deliver_now) begin
        recognized <= 1'b0;
      end
    end
  end

  // Guest interrupt status and the in-service and request words
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_vec <= `VIED_NO_VECTOR;
      svc_vec <= `VIED_NO_VECTOR;
      for (int w = 0; w < 8; w++) begin
        isr_word[w] <= 32'h0;
        irr_word[w] <= 32'h0;
      end
    end else if (ce_i) begin
      if (deliver_now) begin
        isr_word[req_vec[7:5]][req_vec[4:0]] <= 1'b1;
        irr_word[req_vec[7:5]][req_vec[4:0]] <= 1'b0;
        svc_vec <= req_vec;
        req_vec <= next_req_vec;
      end else if (ev_self_ipi_i && vid_en) begin
        irr_word[self_ipi_vector_i[7:5]][self_ipi_vector_i[4:0]] <= 1'b1;
        if (self_ipi_vector_i > req_vec) begin
          req_vec <= self_ipi_vector_i;
        end
      end else if (reg_wr_i) begin
        if (reg_addr_i[11:7] == `VIED_ISR_SEL && reg_addr_i[3:0] == 4'h0) begin
          isr_word[reg_addr_i[6:4]] <= reg_wdata_i;
        end
        if (reg_addr_i[11:7] == `VIED_IRR_SEL && reg_addr_i[3:0] == 4'h0) begin
          irr_word[reg_addr_i[6:4]] <= reg_wdata_i;
        end
        if (reg_addr_i == `VIED_OFF_GIS) begin
          req_vec <= reg_wdata_i[7:0];
          svc_vec <= reg_wdata_i[15:8];
        end
      end
    end
  end

  // Virtual processor priority: delivery, priority virtualization, software
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      proc_prio <= 32'h0;
    end else if (ce_i) begin
      if (deliver_now) begin
        proc_prio <= {24'h0, req_vec & `VIED_CLASS_MASK};
      end else if (ppr_req) begin
        if (task_prio[7:4] >= svc_vec[7:4]) begin
          proc_prio <= {24'h0, task_prio[7:0]};
        end else begin
          proc_prio <= {24'h0, svc_vec & `VIED_CLASS_MASK};
        end
      end else if (reg_wr_i && reg_addr_i == `VIED_OFF_PROC_PRIO) begin
        proc_prio <= reg_wdata_i;
      end
    end
  end

  // Virtual task priority; a shadowed move keeps only the nibble
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      task_prio <= 32'h0;
    end else if (ce_i) begin
      if (tpr_virt) begin
        task_prio <= {24'h0, tpcr_src_i[3:0], 4'h0};
      end else if (reg_wr_i && reg_addr_i == `VIED_OFF_TASK_PRIO) begin
        task_prio <= reg_wdata_i;
      end
    end
  end

  // Execution controls and page frames, software owned
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= `VIED_CTRL_RST;
      acc_frame <= '0;
      vpg_frame <= '0;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == `VIED_OFF_CTRL) begin
        ctrl <= reg_wdata_i[3:0];
      end
      if (reg_addr_i == `VIED_OFF_ACC_FRAME) begin
        acc_frame <= reg_wdata_i[FRAME_W-1:0];
      end
      if (reg_addr_i == `VIED_OFF_VPG_FRAME) begin
        vpg_frame <= reg_wdata_i[FRAME_W-1:0];
      end
    end
  end

  // Read mux; unmapped offsets return zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (reg_addr_i[11:7] == `VIED_ISR_SEL && reg_addr_i[3:0] == 4'h0) begin
      rd_mux = isr_word[reg_addr_i[6:4]];
    end else if (reg_addr_i[11:7] == `VIED_IRR_SEL && reg_addr_i[3:0] == 4'h0) begin
      rd_mux = irr_word[reg_addr_i[6:4]];
    end else begin
      case (reg_addr_i)
        `VIED_OFF_TASK_PRIO: rd_mux = task_prio;
        `VIED_OFF_PROC_PRIO: rd_mux = proc_prio;
        `VIED_OFF_CTRL: rd_mux = {28'h0, ctrl};
        `VIED_OFF_GIS: rd_mux = {15'h0, recognized, svc_vec, req_vec};
        `VIED_OFF_ACC_FRAME: rd_mux = 32'(acc_frame);
        `VIED_OFF_VPG_FRAME: rd_mux = 32'(vpg_frame);
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (ce_i) begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // Delivery outputs toward the pipeline and event arbiter
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      deliver_o <= 1'b0;
      deliver_vector_o <= `VIED_NO_VECTOR;
      ext_int_hold_o <= 1'b0;
      wake_o <= 1'b0;
      recognized_o <= 1'b0;
    end else if (ce_i) begin
      deliver_o <= deliver_now;
      if (deliver_now) begin
        deliver_vector_o <= req_vec;
      end
      // External interrupts must yield while a delivery is pending
      ext_int_hold_o <= deliver_now || (recognized && vid_en && !iwe);
      wake_o <= deliver_now && halted;
      recognized_o <= recognized;
    end
  end

  // Task-priority control-register moves
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tpcr_dest_o <= 64'h0;
      real_tpr_rd_o <= 1'b0;
      real_tpr_wr_o <= 1'b0;
      real_tpr_wdata_o <= 4'h0;
    end else if (ce_i) begin
      real_tpr_rd_o <= mov_from_tpcr_i && !tpr_shadow;
      real_tpr_wr_o <= mov_to_tpcr_i && !tpr_shadow;
      if (mov_to_tpcr_i && !tpr_shadow) begin
        real_tpr_wdata_o <= tpcr_src_i[3:0];
      end
      if (mov_from_tpcr_i) begin
        if (tpr_shadow) begin
          tpcr_dest_o <= {60'h0, task_prio[7:4]};
        end else begin
          tpcr_dest_o <= {60'h0, real_tpr_i[7:4]};
        end
      end
    end
  end

  // Access page check on the final physical address only
  logic acc_hit;
  logic acc_virt;
  assign acc_hit = vacc_en && acc_valid_i &&
                   (acc_phys_addr_i[PA_W-1:`VIED_PAGE_BITS] == acc_frame);
  // A second access after a virtualized write in one operation exits
  assign acc_virt = acc_virt_ok_i && !op_wr_seen;

  // Operation tracking: cleared at the end of each operation
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_wr_seen <= 1'b0;
    end else if (ce_i) begin
      if (op_end_i) begin
        op_wr_seen <= 1'b0;
      end else if (acc_hit && acc_virt && acc_write_i) begin
        op_wr_seen <= 1'b1;
      end
    end
  end

  // Exit or redirect decision, one cycle after the access
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_exit_o <= 1'b0;
      acc_redirect_o <= 1'b0;
      acc_redir_addr_o <= '0;
    end else if (ce_i) begin
      acc_exit_o <= acc_hit && !acc_virt;
      acc_redirect_o <= acc_hit && acc_virt;
      if (acc_hit && acc_virt) begin
        acc_redir_addr_o <= {vpg_frame, acc_phys_addr_i[`VIED_PAGE_BITS-1:0]};
      end
    end
  end

endmodule

// ==== vied_pipe_model.sv ====
`timescale 1ns/1ns
module vied_pipe_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic slow_i,
  output logic boundary_o,
  output logic op_end_o
);
  logic [1:0] cnt;
  // Free running phase of a long multi-cycle instruction
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  // Slow mode: boundary only every fourth cycle, so delivery must wait
  assign boundary_o = !slow_i || cnt == 2'h3;
  assign op_end_o = boundary_o;
endmodule

// ==== vied_core_monitor.sv ====
`timescale 1ns/1ns
module vied_core_monitor import vied_pkg::*; #(
  parameter int PA_W = 44
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic if_flag_i,
  input wire logic intr_shadow_block_i,
  input wire logic higher_event_i,
  input wire vied_activity_t activity_i,
  input wire logic deliver_o,
  input wire vied_vector_t deliver_vector_o,
  input wire logic wake_o,
  input wire logic mov_from_tpcr_i,
  input wire logic mov_to_tpcr_i,
  input wire logic [63:0] tpcr_dest_o,
  input wire logic real_tpr_rd_o,
  input wire logic real_tpr_wr_o,
  input wire logic acc_valid_i,
  input wire logic [PA_W-1:0] acc_phys_addr_i,
  input wire logic acc_exit_o,
  input wire logic acc_redirect_o,
  input wire logic [PA_W-1:0] acc_redir_addr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Read data only in the slot after a read strobe
  property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  // Delivery needs interrupts unblocked and nothing higher pending
  property p_gate;
    deliver_o |-> $past(if_flag_i) && !$past(intr_shadow_block_i) && !$past(higher_event_i);
  endproperty
  a_gate: assert property (p_gate) else $error("delivery while blocked");
  property p_wake;
    wake_o |-> deliver_o && ($past(activity_i) inside {VIED_ACT_HALT, VIED_ACT_MON_WAIT});
  endproperty
  a_wake: assert property (p_wake) else $error("wake without halt delivery");
  property p_dead;
    deliver_o |-> !($past(activity_i) inside {VIED_ACT_SHUTDOWN, VIED_ACT_WAIT_STARTUP});
  endproperty
  a_dead: assert property (p_dead) else $error("delivery in dead state");
  // A delivered vector always beats priority class zero
  property p_vec; deliver_o |-> deliver_vector_o[7:4] != 4'h0; endproperty
  a_vec: assert property (p_vec) else $error("delivered class zero");
  property p_dest; mov_from_tpcr_i |=> real_tpr_rd_o || tpcr_dest_o[63:4] == 60'h0; endproperty
  a_dest: assert property (p_dest) else $error("upper result bits set");
  property p_rrd; real_tpr_rd_o |-> $past(mov_from_tpcr_i); endproperty
  a_rrd: assert property (p_rrd) else $error("stray real read");
  property p_rwr; real_tpr_wr_o |-> $past(mov_to_tpcr_i); endproperty
  a_rwr: assert property (p_rwr) else $error("stray real write");
  property p_acc;
    acc_exit_o || acc_redirect_o |-> $past(acc_valid_i) && !(acc_exit_o && acc_redirect_o);
  endproperty
  a_acc: assert property (p_acc) else $error("bad access outcome");
  property p_redir;
    acc_redirect_o |-> acc_redir_addr_o[11:0] == $past(acc_phys_addr_i[11:0]);
  endproperty
  a_redir: assert property (p_redir) else $error("redirect offset lost");
  c_wake: cover property (wake_o);
  c_redir: cover property (acc_redirect_o);
  c_dlv: cover property (deliver_o);
endmodule
bind vied_core vied_core_monitor #(.PA_W(PA_W)) u_mon (.*);

// ==== tb_virtual_interrupt_eval_delivery.sv ====
`timescale 1ns/1ns
module tb_virtual_interrupt_eval_delivery;
  import vied_pkg::*;
  logic clock_i, arst_n_i, wr, rd, ifl, isb, hev, aw, avo, slow, bnd, oe;
  logic dl, wk, rtr, rtw, ex, rdr, got, wseen;
  logic hold, rcg, ce;
  logic [6:0] ev;
  logic [3:0] rtd;
  logic [11:0] addr;
  logic [31:0] wd, rdata, d;
  logic [63:0] src, dest;
  logic [43:0] pa, ra;
  vied_vector_t sv, dv;
  vied_activity_t act;
  int err_total, comparisons, cyc;
  // Target, class, expected delivery
  logic [23:0] rows [5] = '{24'h352001, 24'h353000, 24'hf1e001, 24'h100001, 24'h2f2000};
  vied_core uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .ev_vm_entry_i(ev[5]), .ev_eoi_virt_i(ev[6]), .ev_self_ipi_i(ev[1]),
    .self_ipi_vector_i(sv), .ev_posted_i(ev[0]), .boundary_i(bnd), .if_flag_i(ifl),
    .intr_shadow_block_i(isb), .ss_block_i(1'b0), .higher_event_i(hev), .activity_i(act),
    .deliver_o(dl), .deliver_vector_o(dv), .ext_int_hold_o(hold), .wake_o(wk),
    .recognized_o(rcg), .mov_from_tpcr_i(ev[2]), .mov_to_tpcr_i(ev[3]), .tpcr_src_i(src),
    .real_tpr_i(8'h00), .tpcr_dest_o(dest), .real_tpr_rd_o(rtr), .real_tpr_wr_o(rtw),
    .real_tpr_wdata_o(rtd), .acc_valid_i(ev[4]), .acc_write_i(aw), .acc_virt_ok_i(avo),
    .acc_phys_addr_i(pa), .op_end_i(oe), .acc_exit_o(ex), .acc_redirect_o(rdr),
    .acc_redir_addr_o(ra));
  vied_pipe_model u_pipe (.clock_i(clock_i), .arst_n_i(arst_n_i), .slow_i(slow),
    .boundary_o(bnd), .op_end_o(oe));
  task automatic end_sim;
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  // Data stands only in the slot after the strobe edge
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic kick(input logic [6:0] e);
    @(posedge clock_i);
    ev <= e;
    @(posedge clock_i);
    ev <= 7'h00;
    #1;
  endtask
  // Bounded watch for a delivery pulse
  task automatic wait_dlv;
    got = 1'b0;
    wseen = 1'b0;
    repeat (10) begin
      @(posedge clock_i);
      #1;
      got = got | dl;
      wseen = wseen | wk;
    end
  endtask
  task automatic arm(input logic [31:0] c, input logic [7:0] v, input logic [4:0] e);
    wr_reg(12'h800, c);
    wr_reg(12'h804, {24'h0, v});
    wr_reg(12'h0a0, 32'h0);
    kick(e);
    wait_dlv;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Hang guard well above the expected run length
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_sim;
    end
  end
  initial begin
    {arst_n_i, wr, rd, ifl, isb, hev, aw, avo, slow, ev, sv, src, pa, addr, wd} = '0;
    act = VIED_ACT_ACTIVE;
    ce = 1'b1;
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd_reg(12'h804);
    chk(d, 32'h0);
    rd_reg(12'h400);
    chk(d, 32'h0);
    ifl <= 1'b1;
    wr_reg(12'h800, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr_reg(12'h804, {24'h0, rows[i][23:16]});
      wr_reg(12'h0a0, {24'h0, rows[i][15:8]});
      kick(5'h01);
      wait_dlv;
      chk(got, rows[i][0]);
      if (rows[i][0]) begin
        chk(dv, rows[i][23:16]);
        rd_reg(12'h0a0);
        chk(d, rows[i][23:16] & 8'hf0);
        rd_reg(12'h804);
        chk(d, {rows[i][23:16], 8'h00});
      end
      $display("row %0d done", i);
    end
    arm(32'h0, 8'h50, 5'h01);
    chk(got, 1'b0);
    wr_reg(12'h800, 32'h1);
    wait_dlv;
    chk(got, 1'b0);
    // Entry and end-of-interrupt events must each start an evaluation
    kick(7'h20);
    wait_dlv;
    chk({got, dv}, {1'b1, 8'h50});
    wr_reg(12'h804, 32'h50a0);
    kick(7'h40);
    wait_dlv;
    chk({got, dv}, {1'b1, 8'ha0});
    arm(32'h3, 8'h60, 5'h01);
    chk(got, 1'b0);
    ifl <= 1'b0;
    arm(32'h1, 8'h70, 5'h01);
    chk(got, 1'b0);
    chk({hold, rcg}, 2'b11);
    ifl <= 1'b1;
    wait_dlv;
    chk({got, dv}, {1'b1, 8'h70});
    wait_dlv;
    chk(got, 1'b0);
    hev <= 1'b1;
    slow <= 1'b1;
    arm(32'h1, 8'h80, 5'h01);
    chk(got, 1'b0);
    hev <= 1'b0;
    wait_dlv;
    chk({got, dv}, {1'b1, 8'h80});
    $display("gating done");
    act <= VIED_ACT_SHUTDOWN;
    arm(32'h1, 8'h90, 5'h01);
    chk(got, 1'b0);
    act <= VIED_ACT_WAIT_STARTUP;
    kick(5'h01);
    wait_dlv;
    chk(got, 1'b0);
    // Halt only after the posted-event kick returns, so the pulse falls inside the watch
    kick(5'h01);
    act <= VIED_ACT_HALT;
    wait_dlv;
    chk({got, wseen, dv}, {2'b11, 8'h90});
    act <= VIED_ACT_ACTIVE;
    ifl <= 1'b0;
    slow <= 1'b0;
    sv <= 8'h45;
    arm(32'h1, 8'h00, 5'h02);
    sv <= 8'h62;
    kick(5'h02);
    ifl <= 1'b1;
    wait_dlv;
    chk({got, dv}, {1'b1, 8'h62});
    rd_reg(12'h804);
    chk(d, 32'h6245);
    rd_reg(12'h220);
    chk(d, 32'h20);
    rd_reg(12'h230);
    chk(d, 32'h0);
    rd_reg(12'h130);
    chk(d, 32'h10004);
    $display("self ipi done");
    wr_reg(12'h800, 32'h5);
    src <= 64'hffffffffffffffa7;
    kick(5'h08);
    rd_reg(12'h080);
    chk(d, 32'h70);
    kick(5'h04);
    chk(dest, 64'h7);
    wr_reg(12'h800, 32'h0);
    kick(5'h08);
    chk({rtw, rtd}, {1'b1, 4'h7});
    kick(5'h04);
    chk(rtr, 1'b1);
    wr_reg(12'h808, 32'h000abcde);
    wr_reg(12'h80c, 32'h00012345);
    wr_reg(12'h800, 32'h8);
    pa <= {32'h000abcde, 12'h080};
    kick(5'h10);
    chk({ex, rdr}, 2'b10);
    avo <= 1'b1;
    kick(5'h10);
    chk({rdr, ra}, {1'b1, 32'h00012345, 12'h080});
    pa <= {32'h000abcdf, 12'h080};
    kick(5'h10);
    chk({ex, rdr}, 2'b00);
    // Clock enable low must freeze a register write
    wr_reg(12'h0a0, 32'h33);
    ce <= 1'b0;
    wr_reg(12'h0a0, 32'h55);
    ce <= 1'b1;
    rd_reg(12'h0a0);
    chk(d, 32'h33);
    $display("tpr and access done");
    end_sim;
  end
endmodule
